// File: hw/eor_pkg.sv
//------------------------------------------------------------------------------
// Purpose: Constants, types and register map of the expansion output routing
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   Gain is unsigned fixed point with 12 fraction bits
//------------------------------------------------------------------------------
package eor_pkg;

	//--------------------------------------------------------------------------
	// Register byte offsets
	//--------------------------------------------------------------------------
	localparam logic [7:0]  OFS_CTRL       = 8'h00;
	localparam logic [7:0]  OFS_AO3_TYPE   = 8'h04;
	localparam logic [7:0]  OFS_AO4_GAIN   = 8'h08;
	localparam logic [7:0]  OFS_AO4_SRC    = 8'h0c;
	localparam logic [7:0]  OFS_DOUT_CFG   = 8'h10;
	localparam logic [7:0]  OFS_ARM_AMPS   = 8'h14;
	localparam logic [7:0]  OFS_MAX_CUR    = 8'h18;
	localparam logic [7:0]  OFS_TOP_SPEED  = 8'h1c;
	localparam logic [7:0]  OFS_ARM_VOLTS  = 8'h20;
	localparam logic [7:0]  OFS_FIELD_AMPS = 8'h24;
	localparam logic [7:0]  OFS_STATUS     = 8'h28;
	localparam logic [7:0]  OFS_AO4_LEVEL  = 8'h2c;

	//--------------------------------------------------------------------------
	// Field positions
	//--------------------------------------------------------------------------
	localparam int unsigned INIT_DONE_BIT  = 0;
	localparam int unsigned DO1_SRC_LSB    = 0;
	localparam int unsigned DO2_SRC_LSB    = 2;
	localparam int unsigned DO1_NC_BIT     = 4;
	localparam int unsigned DO2_NC_BIT     = 5;

	//--------------------------------------------------------------------------
	// Reset values and limits
	//--------------------------------------------------------------------------
	localparam logic [1:0]  AO3_TYPE_RST   = 2'h1;
	localparam logic [15:0] GAIN_MIN       = 16'h0800;
	localparam logic [15:0] GAIN_MAX       = 16'h14cd;
	localparam logic [15:0] GAIN_RST       = 16'h1000;
	localparam int unsigned GAIN_FRAC      = 12;
	localparam logic [4:0]  SRC_MAX        = 5'h16;
	localparam logic [4:0]  SRC_RST        = 5'h00;
	localparam logic [1:0]  DO1_SRC_RST    = 2'h0;
	localparam logic [1:0]  DO2_SRC_RST    = 2'h1;
	localparam logic [15:0] RATING_RST     = 16'h0001;
	localparam logic [15:0] OUTER_FS       = 16'h0fff;
	localparam logic [6:0]  PCT_SCALE      = 7'h64;
	localparam logic [11:0] AO_MAX         = 12'h7ff;

	//--------------------------------------------------------------------------
	// Analog output 4 source codes
	//--------------------------------------------------------------------------
	localparam logic [4:0]  SRC_CUR_FDBK   = 5'h00;
	localparam logic [4:0]  SRC_CUR_REF    = 5'h01;
	localparam logic [4:0]  SRC_CUR_ERR    = 5'h02;
	localparam logic [4:0]  SRC_SPD_OUT    = 5'h06;
	localparam logic [4:0]  SRC_ARM_VOLT   = 5'h0b;
	localparam logic [4:0]  SRC_ZERO       = 5'h0e;
	localparam logic [4:0]  SRC_FULL       = 5'h0f;
	localparam logic [4:0]  SRC_POWER      = 5'h10;
	localparam logic [4:0]  SRC_OUTER_REF  = 5'h11;
	localparam logic [4:0]  SRC_OUTER_RAMP = 5'h12;
	localparam logic [4:0]  SRC_OUTER_FDBK = 5'h13;
	localparam logic [4:0]  SRC_FIELD_REF  = 5'h15;
	localparam logic [4:0]  SRC_FIELD_FDBK = 5'h16;

	//--------------------------------------------------------------------------
	// Scaling arithmetic widths and timing
	//--------------------------------------------------------------------------
	localparam int unsigned NUM_W          = 56;
	localparam int unsigned DEN_W          = 60;
	localparam logic [5:0]  DIV_STEPS      = 6'h37;

	//--------------------------------------------------------------------------
	// Types
	//--------------------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_LOAD = 2'b00,
		ST_DIV  = 2'b01,
		ST_SAT  = 2'b11,
		ST_DONE = 2'b10
	} eor_state_type;

	typedef struct packed {
		logic [1:0]  ao3_type;
		logic [15:0] ao4_gain;
		logic [4:0]  ao4_src;
		logic [1:0]  do1_src;
		logic [1:0]  do2_src;
		logic        do1_nc;
		logic        do2_nc;
	} eor_cfg_type;

	typedef struct packed {
		logic [15:0] arm_amps;
		logic [15:0] max_cur_pct;
		logic [15:0] top_speed;
		logic [15:0] arm_volts;
		logic [15:0] field_amps;
	} eor_rating_type;

	typedef struct packed {
		logic drive_ready;
		logic in_cur_limit;
		logic monitor2;
		logic monitor1;
	} eor_dsrc_type;

	typedef logic [22:0][15:0] eor_asrc_type;

endpackage : eor_pkg

// File: hw/eor_output_routing.sv
//------------------------------------------------------------------------------
// Purpose: Expansion board output routing: analog out 3 type, analog out 4
//          source, scaling and gain, two relay contacts with polarity
// Assumes: Source signals come from logic on pclk; APB master on pclk
// Notes:   Analog out 4 refreshes about every 60 cycles
//------------------------------------------------------------------------------
// How it works
// - Two-bit analog out 3 type, default one
// - Analog out 4 gain 0.5 to 1.3, default 1
// - Route one of 23 sources to analog out 4
// - Output maximum exactly at source full scale
// - Current sources scale by amps times percent
// - Speed sources scale by top speed
// - Armature voltage scales by rated volts
// - Power scales by volts, amps, percent
// - Field sources scale by rated field amps
// - Outer loop sources scale by 4095
// - Digital out 1 picks one of four flags
// - Digital out 2 same choices, default one
// - Digital out 1 polarity bit, default open
// - Digital out 2 polarity bit, default open
// - Digital out 1 contact follows signal, polarity
// - Digital out 2 contact follows signal, polarity
// - Contacts open until initialization completes
`timescale 1ns/100ps

module eor_output_routing
	import eor_pkg::*;
(
	input  wire logic                pclk,          // Bus and core clock
	input  wire logic                presetn,       // Async reset, low
	input  wire logic                ce,            // Clock enable
	input  wire logic                psel,          // APB select
	input  wire logic                penable,       // APB access phase
	input  wire logic                pwrite,        // APB write
	input  wire logic [7:0]          paddr,         // APB byte address
	input  wire logic [31:0]         pwdata,        // APB write data
	output logic      [31:0]         prdata,        // APB read data
	output logic                     pready,        // APB ready
	output logic                     pslverr,       // APB error
	input  wire eor_asrc_type        analog_src,    // 23 signed sources
	input  wire eor_dsrc_type        digital_src,   // Contact flags
	output logic      [1:0]          ao3_type,      // Analog out 3 type
	output logic signed [11:0]       ao4_level,     // Analog out 4 level
	output logic                     ao4_saturated, // Gain clipped output
	output logic                     dout1_closed,  // Contact 1 closed
	output logic                     dout2_closed   // Contact 2 closed
);

	//--------------------------------------------------------------------------
	// Functions
	//--------------------------------------------------------------------------
	function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo,
		input logic [31:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	function automatic logic pick_flag(input logic [1:0] sel, input eor_dsrc_type f);
		logic r;
		r = 1'b0;
		case (sel)
			2'h0:    r = f.monitor1;
			2'h1:    r = f.monitor2;
			2'h2:    r = f.in_cur_limit;
			default: r = f.drive_ready;
		endcase
		pick_flag = r;
	endfunction : pick_flag

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a[1:0] == 2'h0) && (a <= OFS_AO4_LEVEL);
	endfunction : is_mapped

	//--------------------------------------------------------------------------
	// Declarations
	//--------------------------------------------------------------------------
	eor_cfg_type                cfg_reg;
	eor_rating_type             rating_reg;
	logic                       init_done_reg;
	logic                       pready_reg;
	logic                       pslverr_reg;
	logic [31:0]                prdata_reg;
	logic [31:0]                rd_next;
	logic                       wr_go;
	logic                       rd_go;
	logic                       dout1_reg;
	logic                       dout2_reg;
	eor_state_type              state_reg;
	logic [5:0]                 step_reg;
	logic [NUM_W-1:0]           num_reg;
	logic [DEN_W-1:0]           den_reg;
	logic [DEN_W-1:0]           rem_reg;
	logic [NUM_W-1:0]           quo_reg;
	logic                       neg_reg;
	logic [11:0]                mag_reg;
	logic                       sat_reg;
	logic signed [11:0]         level_reg;
	logic                       level_sat_reg;
	logic [15:0]                src_abs;
	logic                       src_neg;
	logic [47:0]                fs_next;
	logic [6:0]                 mult_next;
	logic [NUM_W-1:0]           num_next;
	logic [DEN_W:0]             trial;

	//--------------------------------------------------------------------------
	// APB handshake
	//--------------------------------------------------------------------------
	// One wait state: ready rises in the second access cycle
	assign wr_go = psel && penable && pready_reg && pwrite;
	assign rd_go = psel && penable && !pready_reg && !pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else if (ce) begin
			pready_reg  <= psel && penable && !pready_reg;
			pslverr_reg <= psel && penable && !pready_reg && !is_mapped(paddr);
		end
	end

	// Read data is captured on the same edge that raises ready
	always_comb begin
		rd_next = 32'h0000_0000;
		case (paddr)
			OFS_CTRL:       rd_next[INIT_DONE_BIT] = init_done_reg;
			OFS_AO3_TYPE:   rd_next[1:0] = cfg_reg.ao3_type;
			OFS_AO4_GAIN:   rd_next[15:0] = cfg_reg.ao4_gain;
			OFS_AO4_SRC:    rd_next[4:0] = cfg_reg.ao4_src;
			OFS_DOUT_CFG: begin
				rd_next[DO1_SRC_LSB +: 2] = cfg_reg.do1_src;
				rd_next[DO2_SRC_LSB +: 2] = cfg_reg.do2_src;
				rd_next[DO1_NC_BIT]       = cfg_reg.do1_nc;
				rd_next[DO2_NC_BIT]       = cfg_reg.do2_nc;
			end
			OFS_ARM_AMPS:   rd_next[15:0] = rating_reg.arm_amps;
			OFS_MAX_CUR:    rd_next[15:0] = rating_reg.max_cur_pct;
			OFS_TOP_SPEED:  rd_next[15:0] = rating_reg.top_speed;
			OFS_ARM_VOLTS:  rd_next[15:0] = rating_reg.arm_volts;
			OFS_FIELD_AMPS: rd_next[15:0] = rating_reg.field_amps;
			OFS_STATUS:     rd_next[2:0] = {level_sat_reg, dout2_reg, dout1_reg};
			OFS_AO4_LEVEL:  rd_next[11:0] = level_reg;
			default:        rd_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (ce && rd_go) begin
			prdata_reg <= rd_next;
		end
	end

	//--------------------------------------------------------------------------
	// Configuration registers
	//--------------------------------------------------------------------------
	// Bad codes keep the old value so a typo cannot select a bogus source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg.ao3_type <= AO3_TYPE_RST;
			cfg_reg.ao4_gain <= GAIN_RST;
			cfg_reg.ao4_src  <= SRC_RST;
			cfg_reg.do1_src  <= DO1_SRC_RST;
			cfg_reg.do2_src  <= DO2_SRC_RST;
			cfg_reg.do1_nc   <= 1'b0;
			cfg_reg.do2_nc   <= 1'b0;
			init_done_reg    <= 1'b0;
		end else if (ce && wr_go) begin
			case (paddr)
				OFS_CTRL: begin
					init_done_reg <= pwdata[INIT_DONE_BIT];
				end
				OFS_AO3_TYPE: begin
					if (in_range(pwdata, 32'h0, 32'h3)) begin
						cfg_reg.ao3_type <= pwdata[1:0];
					end
				end
				OFS_AO4_GAIN: begin
					if (in_range(pwdata, {16'h0, GAIN_MIN}, {16'h0, GAIN_MAX})) begin
						cfg_reg.ao4_gain <= pwdata[15:0];
					end
				end
				OFS_AO4_SRC: begin
					if (in_range(pwdata, 32'h0, {27'h0, SRC_MAX})) begin
						cfg_reg.ao4_src <= pwdata[4:0];
					end
				end
				OFS_DOUT_CFG: begin
					if (in_range(pwdata, 32'h0, 32'h3f)) begin
						cfg_reg.do1_src <= pwdata[DO1_SRC_LSB +: 2];
						cfg_reg.do2_src <= pwdata[DO2_SRC_LSB +: 2];
						cfg_reg.do1_nc  <= pwdata[DO1_NC_BIT];
						cfg_reg.do2_nc  <= pwdata[DO2_NC_BIT];
					end
				end
				default: begin
				end
			endcase
		end
	end

	//--------------------------------------------------------------------------
	// Motor ratings used as full-scale bases
	//--------------------------------------------------------------------------
	// A zero rating would make full scale zero, so it is refused
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rating_reg <= {5{RATING_RST}};
		end else if (ce && wr_go && (pwdata[15:0] != 16'h0000) && (pwdata[31:16] == 16'h0000)) begin
			case (paddr)
				OFS_ARM_AMPS:   rating_reg.arm_amps    <= pwdata[15:0];
				OFS_MAX_CUR:    rating_reg.max_cur_pct <= pwdata[15:0];
				OFS_TOP_SPEED:  rating_reg.top_speed   <= pwdata[15:0];
				OFS_ARM_VOLTS:  rating_reg.arm_volts   <= pwdata[15:0];
				OFS_FIELD_AMPS: rating_reg.field_amps  <= pwdata[15:0];
				default: begin
				end
			endcase
		end
	end

	//--------------------------------------------------------------------------
	// Source selection and full scale
	//--------------------------------------------------------------------------
	// Divide-by-100 terms move into the numerator to stay exact
	always_comb begin
		src_abs   = analog_src[cfg_reg.ao4_src][15] ?
			16'(-analog_src[cfg_reg.ao4_src]) : analog_src[cfg_reg.ao4_src];
		src_neg   = analog_src[cfg_reg.ao4_src][15];
		fs_next   = {32'h0, rating_reg.top_speed};
		mult_next = 7'h01;
		case (cfg_reg.ao4_src)
			SRC_CUR_FDBK, SRC_CUR_REF, SRC_CUR_ERR, SRC_SPD_OUT: begin
				fs_next   = 48'(rating_reg.arm_amps) * 48'(rating_reg.max_cur_pct);
				mult_next = PCT_SCALE;
			end
			SRC_ARM_VOLT: begin
				fs_next = {32'h0, rating_reg.arm_volts};
			end
			SRC_POWER: begin
				fs_next   = 48'(rating_reg.arm_volts) * 48'(rating_reg.arm_amps) * 48'(rating_reg.max_cur_pct);
				mult_next = PCT_SCALE;
			end
			SRC_FIELD_REF, SRC_FIELD_FDBK: begin
				fs_next = {32'h0, rating_reg.field_amps};
			end
			SRC_OUTER_REF, SRC_OUTER_RAMP, SRC_OUTER_FDBK: begin
				fs_next = {32'h0, OUTER_FS};
			end
			SRC_ZERO: begin
				src_abs = 16'h0000;
				src_neg = 1'b0;
				fs_next = 48'h1;
			end
			SRC_FULL: begin
				src_abs = 16'h0001;
				src_neg = 1'b0;
				fs_next = 48'h1;
			end
			default: begin
			end
		endcase
		// Output = |src| * max * gain / full scale
		num_next = NUM_W'(src_abs) * NUM_W'(AO_MAX) * NUM_W'(mult_next) * NUM_W'(cfg_reg.ao4_gain);
	end

	//--------------------------------------------------------------------------
	// Scaling state machine
	//--------------------------------------------------------------------------
	// Bit-serial divider: slow, but far smaller than a wide array divider
	assign trial = {rem_reg, num_reg[NUM_W-1]};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_LOAD;
			step_reg  <= 6'h00;
			num_reg   <= '0;
			den_reg   <= '0;
			rem_reg   <= '0;
			quo_reg   <= '0;
			neg_reg   <= 1'b0;
			mag_reg   <= 12'h000;
			sat_reg   <= 1'b0;
		end else if (ce) begin
			case (state_reg)
				ST_LOAD: begin
					num_reg   <= num_next;
					den_reg   <= DEN_W'({fs_next, 12'h000});
					rem_reg   <= '0;
					quo_reg   <= '0;
					neg_reg   <= src_neg;
					step_reg  <= DIV_STEPS;
					state_reg <= ST_DIV;
				end
				ST_DIV: begin
					if (trial >= {1'b0, den_reg}) begin
						rem_reg <= DEN_W'(trial - {1'b0, den_reg});
						quo_reg <= {quo_reg[NUM_W-2:0], 1'b1};
					end else begin
						rem_reg <= trial[DEN_W-1:0];
						quo_reg <= {quo_reg[NUM_W-2:0], 1'b0};
					end
					num_reg  <= {num_reg[NUM_W-2:0], 1'b0};
					step_reg <= step_reg - 6'h01;
					if (step_reg == 6'h00) begin
						state_reg <= ST_SAT;
					end
				end
				ST_SAT: begin
					// Clip rather than wrap when gain pushes past maximum
					if (quo_reg > {{(NUM_W-12){1'b0}}, AO_MAX}) begin
						mag_reg <= AO_MAX;
						sat_reg <= 1'b1;
					end else begin
						mag_reg <= quo_reg[11:0];
						sat_reg <= 1'b0;
					end
					state_reg <= ST_DONE;
				end
				ST_DONE: begin
					state_reg <= ST_LOAD;
				end
				default: begin
					state_reg <= ST_LOAD;
				end
			endcase
		end
	end

	// Signed level is published only once a conversion is complete
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_reg     <= 12'sh000;
			level_sat_reg <= 1'b0;
		end else if (ce && (state_reg == ST_DONE)) begin
			level_reg     <= neg_reg ? 12'(-mag_reg) : mag_reg;
			level_sat_reg <= sat_reg;
		end
	end

	//--------------------------------------------------------------------------
	// Relay contacts
	//--------------------------------------------------------------------------
	// Held open until software marks initialization done
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout1_reg <= 1'b0;
			dout2_reg <= 1'b0;
		end else if (ce) begin
			dout1_reg <= init_done_reg && (pick_flag(cfg_reg.do1_src, digital_src) ^ cfg_reg.do1_nc);
			dout2_reg <= init_done_reg && (pick_flag(cfg_reg.do2_src, digital_src) ^ cfg_reg.do2_nc);
		end
	end

	//--------------------------------------------------------------------------
	// Outputs
	//--------------------------------------------------------------------------
	assign prdata        = prdata_reg;
	assign pready        = pready_reg;
	assign pslverr       = pslverr_reg;
	assign ao3_type      = cfg_reg.ao3_type;
	assign ao4_level     = level_reg;
	assign ao4_saturated = level_sat_reg;
	assign dout1_closed  = dout1_reg;
	assign dout2_closed  = dout2_reg;

endmodule : eor_output_routing

// File: testbench/eor_checker.sv
// Purpose: Bus and output checks for the output routing block
// Assumes: Master holds each request until pready
// Notes:   Shadow copies track the settings behind the contacts
`timescale 1ns/100ps

module eor_checker
	import eor_pkg::*;
(
	input wire logic               pclk,          // Clock
	input wire logic               presetn,       // Reset, low
	input wire logic               ce,            // Clock enable
	input wire logic               psel,          // Select
	input wire logic               penable,       // Access phase
	input wire logic               pwrite,        // Write
	input wire logic [7:0]         paddr,         // Address
	input wire logic [31:0]        pwdata,        // Write data
	input wire logic [31:0]        prdata,        // Read data
	input wire logic               pready,        // Ready
	input wire logic               pslverr,       // Error
	input wire eor_asrc_type       analog_src,    // Sources
	input wire eor_dsrc_type       digital_src,   // Flags
	input wire logic [1:0]         ao3_type,      // Out 3 type
	input wire logic signed [11:0] ao4_level,     // Out 4 level
	input wire logic               ao4_saturated, // Clipped
	input wire logic               dout1_closed,  // Contact 1
	input wire logic               dout2_closed   // Contact 2
);
	logic [5:0] cfg_q;  // Contact settings copy
	logic       init_q; // Init flag copy
	logic [1:0] type_q; // Type copy
	logic [3:0] flags;  // Flags as bits
	logic       wr;     // Write taken
	logic       exp1;   // Contact 1 expected
	logic       exp2;   // Contact 2 expected
	logic       bad;    // Unmapped address

	// Shadow state follows accepted writes only
	assign flags = digital_src;
	assign wr = psel && penable && pready && pwrite && ce;
	assign exp1 = init_q && (flags[cfg_q[1:0]] ^ cfg_q[4]);
	assign exp2 = init_q && (flags[cfg_q[3:2]] ^ cfg_q[5]);
	assign bad = (paddr[1:0] != 2'h0) || (paddr > OFS_AO4_LEVEL);

	// Out-of-range writes leave the copies alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q <= 6'h04;
			init_q <= 1'b0;
			type_q <= AO3_TYPE_RST;
		end else if (wr) begin
			if (paddr == OFS_DOUT_CFG && pwdata[31:6] == 26'h0) cfg_q <= pwdata[5:0];
			if (paddr == OFS_CTRL) init_q <= pwdata[0];
			if (paddr == OFS_AO3_TYPE && pwdata[31:2] == 30'h0) type_q <= pwdata[1:0];
		end
	end

	// ------
	// Properties
	// ------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ready_wait: assert property (psel && !penable && ce |=> !pready ##1 pready) else $error("wait state wrong");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	a_err_addr: assert property (pready |-> pslverr == bad) else $error("pslverr wrong");
	a_type_copy: assert property (ao3_type == type_q) else $error("ao3 type wrong");
	a_contact_one: assert property ($past(ce) |-> dout1_closed == $past(exp1)) else $error("contact 1 wrong");
	a_contact_two: assert property ($past(ce) |-> dout2_closed == $past(exp2)) else $error("contact 2 wrong");
	a_open_preinit: assert property (!init_q |=> !dout1_closed && !dout2_closed) else $error("contact early");
	a_level_range: assert property (ao4_level != 12'h800) else $error("level out of range");
	a_sat_clip: assert property ($rose(ao4_saturated) |-> ##[0:2] ao4_level inside {12'h7ff, 12'h801})
		else $error("clip level wrong");

	c_cfg_write: cover property (wr && paddr == OFS_DOUT_CFG);
	c_contact: cover property ($rose(dout1_closed));
	c_sat: cover property ($rose(ao4_saturated));
	c_err: cover property (pready && pslverr);
endmodule : eor_checker

bind eor_output_routing eor_checker eor_checker_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .analog_src(analog_src), .digital_src(digital_src), .ao3_type(ao3_type),
	.ao4_level(ao4_level), .ao4_saturated(ao4_saturated), .dout1_closed(dout1_closed), .dout2_closed(dout2_closed));

// File: testbench/eor_equip_model.sv
// Purpose: External equipment on the board terminals
// Assumes: Lamps on the contacts, a meter on analog out 4
// Notes:   Readings lag the outputs by one clock
`timescale 1ns/100ps

module eor_equip_model (
	input wire logic               pclk,         // Clock
	input wire logic               dout1_closed, // Contact 1
	input wire logic               dout2_closed, // Contact 2
	input wire logic signed [11:0] ao4_level,    // Analog out 4
	output logic [1:0]             lamps,        // Lit per contact
	output logic signed [11:0]     meter         // Meter reading
);
	// Sampled like a real meter, never ahead of the outputs
	always_ff @(posedge pclk) begin
		lamps <= {dout2_closed, dout1_closed};
		meter <= ao4_level;
	end
endmodule : eor_equip_model

// File: testbench/tb.sv
// Purpose: Self-checking bench for the output routing block
// Assumes: Ratings 100 A, 150 %, speed 1000, 500 V, 20 A field
// Notes:   Analog rows wait 130 cycles, past the 118-cycle bound
`timescale 1ns/100ps

module tb
	import eor_pkg::*;
;
	typedef struct packed {
		logic [4:0]  code;
		logic [15:0] gain;
		logic [15:0] src;
		logic [11:0] lvl;
		logic        sat;
	} eor_row_type;

	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, ao4_saturated, dout1_closed, dout2_closed, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  ao3_type, lamps;
	logic signed [11:0] ao4_level, meter;
	eor_asrc_type analog_src;
	eor_dsrc_type digital_src;
	int mismatches = 0, samples_checked = 0;
	logic [7:0]  rst_a [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
	logic [31:0] rst_v [10] = '{32'h0, 32'h1, 32'h1000, 32'h0, 32'h4, 32'h1, 32'h1, 32'h1, 32'h1, 32'h1};
	eor_row_type rows [15] = '{
		'{5'h00, 16'h1000, 16'h004b, 12'h3ff, 1'b0}, '{5'h06, 16'h1000, 16'hff6a, 12'h801, 1'b0},
		'{5'h03, 16'h1000, 16'h01f4, 12'h3ff, 1'b0}, '{5'h0b, 16'h1000, 16'h01f4, 12'h7ff, 1'b0},
		'{5'h10, 16'h1000, 16'h7530, 12'h332, 1'b0}, '{5'h15, 16'h1000, 16'h000a, 12'h3ff, 1'b0},
		'{5'h13, 16'h1000, 16'h0800, 12'h3ff, 1'b0}, '{5'h0e, 16'h1000, 16'h03e8, 12'h000, 1'b0},
		'{5'h0f, 16'h0800, 16'h0000, 12'h3ff, 1'b0}, '{5'h00, 16'h14cd, 16'h0096, 12'h7ff, 1'b1},
		'{5'h03, 16'h0800, 16'h03e8, 12'h3ff, 1'b0}, '{5'h16, 16'h1000, 16'hffec, 12'h801, 1'b0},
		'{5'h0c, 16'h1000, 16'h00fa, 12'h1ff, 1'b0}, '{5'h07, 16'h14cd, 16'hfc18, 12'h801, 1'b1},
		'{5'h0f, 16'h14cd, 16'h0000, 12'h7ff, 1'b1}};

	eor_output_routing eor_output_routing_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .analog_src(analog_src), .digital_src(digital_src), .ao3_type(ao3_type),
		.ao4_level(ao4_level), .ao4_saturated(ao4_saturated), .dout1_closed(dout1_closed),
		.dout2_closed(dout2_closed));
	eor_equip_model eor_equip_model_i (.pclk(pclk), .dout1_closed(dout1_closed), .dout2_closed(dout2_closed),
		.ao4_level(ao4_level), .lamps(lamps), .meter(meter));

	// ------
	// Tasks
	// ------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One idle cycle after each transfer keeps psel from being set twice at one edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic do_reset();
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask : do_reset

	task automatic check_reset();
		for (int i = 0; i < 10; i++) begin
			apb(rst_a[i], 1'b0, 32'h0);
			chk("reset value", rd, rst_v[i]);
		end
		chk("reset outputs", {17'h0, ao4_saturated, ao4_level, ao3_type}, 32'h1);
		chk("lamps", {30'h0, lamps}, 32'h0);
		$display("test reset done");
	endtask : check_reset

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	initial begin
		#100000;
		mismatches++;
		conclude();
	end

	// ------
	// Main sequence
	// ------
	initial begin
		logic [3:0] pat;
		logic [1:0] ex;
		logic [5:0] cfg;
		{presetn, ce, psel, penable, pwrite, paddr, pwdata, digital_src} = {2'b01, 3'b000, 8'h00, 32'h0, 4'h0};
		analog_src = '0;
		@(posedge pclk);
		do_reset();
		check_reset();
		apb(OFS_ARM_AMPS, 1'b1, 32'h64);
		apb(OFS_MAX_CUR, 1'b1, 32'h96);
		apb(OFS_TOP_SPEED, 1'b1, 32'h3e8);
		apb(OFS_ARM_VOLTS, 1'b1, 32'h1f4);
		apb(OFS_FIELD_AMPS, 1'b1, 32'h14);
		foreach (rows[r]) begin
			for (int k = 0; k < 23; k++) analog_src[k] <= (k == rows[r].code) ? rows[r].src : 16'h0100;
			apb(OFS_AO4_SRC, 1'b1, {27'h0, rows[r].code});
			apb(OFS_AO4_GAIN, 1'b1, {16'h0, rows[r].gain});
			repeat (130) @(posedge pclk);
			chk("meter", {20'h0, meter}, {20'h0, rows[r].lvl});
			apb(OFS_AO4_LEVEL, 1'b0, 32'h0);
			chk("level reg", rd, {20'h0, rows[r].lvl});
			apb(OFS_STATUS, 1'b0, 32'h0);
			chk("saturated", {30'h0, rd[2], ao4_saturated}, {30'h0, {2{rows[r].sat}}});
		end
		$display("test analog done");
		for (int i = 0; i < 2; i++) begin
			apb(OFS_CTRL, 1'b1, 32'(i));
			for (int s = 0; s < 4; s++) begin
				for (int p = 0; p < 4; p++) begin
					pat = p[0] ? 4'ha : 4'h5;
					digital_src <= pat;
					cfg = {p[0] ^ p[1], p[1], 2'(3 - s), 2'(s)};
					apb(OFS_DOUT_CFG, 1'b1, {26'h0, cfg});
					repeat (2) @(posedge pclk);
					ex = {1'(i) & (pat[3 - s] ^ cfg[5]), 1'(i) & (pat[s] ^ cfg[4])};
					chk("lamps", {30'h0, lamps}, {30'h0, ex});
				end
			end
		end
		ce <= 1'b0;
		digital_src <= 4'h5;
		repeat (3) @(posedge pclk);
		chk("frozen", {30'h0, lamps}, 32'h0);
		ce <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("thawed", {30'h0, lamps}, 32'h3);
		$display("test contacts done");
		for (int t = 0; t < 5; t++) begin
			apb(OFS_AO3_TYPE, 1'b1, 32'(t));
			chk("ao3 type", {30'h0, ao3_type}, (t == 4) ? 32'h3 : 32'(t));
		end
		apb(OFS_AO4_SRC, 1'b1, 32'h17);
		apb(OFS_AO4_SRC, 1'b0, 32'h0);
		chk("src kept", rd, 32'h0f);
		apb(OFS_AO4_GAIN, 1'b1, 32'h07ff);
		apb(OFS_AO4_GAIN, 1'b1, 32'h14ce);
		apb(OFS_AO4_GAIN, 1'b0, 32'h0);
		chk("gain kept", rd, 32'h14cd);
		apb(OFS_DOUT_CFG, 1'b1, 32'h40);
		apb(OFS_DOUT_CFG, 1'b0, 32'h0);
		chk("cfg kept", rd, {26'h0, cfg});
		apb(8'h30, 1'b0, 32'h0);
		chk("unmapped err", {31'h0, er}, 32'h1);
		chk("unmapped data", rd, 32'h0);
		apb(8'h06, 1'b1, 32'h0);
		chk("unaligned err", {31'h0, er}, 32'h1);
		$display("test refusals done");
		do_reset();
		check_reset();
		conclude();
	end
endmodule : tb
